// ==== design/slm_mixer.sv ====
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module slm_mixer #(
  parameter int SAMPLE_CYC   = slm_pkg::CLK_HZ / slm_pkg::SAMPLE_HZ,
  parameter int FEG_TIME_DIV = 1
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [15:0] IN_SAMPLE,
  input  wire logic        IN_VALID,
  output logic             IN_READY,
  input  wire logic [9:0]  ENV_ATTEN,
  input  wire logic [255:0] DSP_OUT,
  input  wire logic [15:0] EXT_L,
  input  wire logic [15:0] EXT_R,
  output logic      [15:0] OUT_L,
  output logic      [15:0] OUT_R,
  output logic      [15:0] MIX_OUT,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  output logic      [7:0]  PITCH_CENTS
);
  typedef logic [47:0] slm_word_t;

  // register fields
  logic [31:0] lfo_q, lfo_d, lvl_q, lvl_d, eff_q, eff_d, fenv_q, fenv_d;
  logic [31:0] flvl_q, flvl_d, rdata_d;
  logic [4:0] lfo_rate_sel, direct_pan, effect_pan, eff_slot, fenv_rate;
  logic [1:0] amp_mod_wave_sel, pitch_mod_wave_sel;
  logic [2:0] amp_mod_depth, pitch_mod_depth;
  logic [7:0] total_level_atten, resonance;
  logic [3:0] direct_send_level, master_volume, effect_send_level;
  logic [3:0] input_mix_send_level, key_rate_scale, octave_sel;
  logic       pitch_fraction_msb;

  assign lfo_rate_sel         = lfo_q[4:0];
  assign amp_mod_wave_sel     = lfo_q[6:5];
  assign amp_mod_depth        = lfo_q[10:8];
  assign pitch_mod_wave_sel   = lfo_q[13:12];
  assign pitch_mod_depth      = lfo_q[18:16];
  assign total_level_atten    = lvl_q[7:0];
  assign direct_send_level    = lvl_q[11:8];
  assign direct_pan           = lvl_q[20:16];
  assign master_volume        = lvl_q[27:24];
  assign effect_send_level    = eff_q[3:0];
  assign effect_pan           = eff_q[12:8];
  assign eff_slot             = eff_q[20:16];
  assign input_mix_send_level = eff_q[27:24];
  assign fenv_rate            = fenv_q[4:0];
  assign key_rate_scale       = fenv_q[11:8];
  assign octave_sel           = fenv_q[15:12];
  assign pitch_fraction_msb   = fenv_q[16];
  assign resonance            = fenv_q[31:24];

  // datapath state
  logic [slm_pkg::PHASE_W-1:0] phase_q, phase_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic [slm_pkg::LVL_W-1:0] env_q, env_d;
  logic [31:0] env_cnt_q, env_cnt_d;
  logic signed [23:0] low_q, low_d, band_q, band_d;
  logic [7:0] amp_mod_value, pitch_mod_value, cents_q, cents_d;
  logic [5:0] eff_rate;
  logic [31:0] env_period;
  slm_word_t head_q, head_d, skid_q, skid_d, word;
  logic hv_q, hv_d, sv_q, sv_d, take;

  function automatic logic [slm_pkg::PHASE_W-1:0] lfo_inc(input logic [4:0] s);
    longint v;
    v = (longint'(slm_pkg::LFO_CHZ[s]) << slm_pkg::PHASE_W)
        / (longint'(slm_pkg::SAMPLE_HZ) * 100);
    return v[slm_pkg::PHASE_W-1:0];
  endfunction : lfo_inc

  // volume code to attenuation units, 0 mutes
  function automatic int vol_att(input logic [3:0] v);
    return (v == 4'h0) ? slm_pkg::MUTE_ATT
                       : int'(slm_pkg::VOL_FULL - v) * slm_pkg::STEP3DB;
  endfunction : vol_att

  // pan code to left/right units; low nibble f mutes that side
  function automatic int pan_att(input logic [4:0] p, input logic right);
    if (p[4] != right) return 0;
    return (p[3:0] == slm_pkg::VOL_FULL) ? slm_pkg::MUTE_ATT
                                         : int'(p[3:0]) * slm_pkg::STEP3DB;
  endfunction : pan_att

  // shift by whole 6 dB, linear approximation inside the step
  function automatic logic signed [15:0] atten(input logic signed [15:0] x,
                                               input int u);
    logic signed [31:0] y;
    int sh;
    y  = 32'(x);
    sh = u >>> 4;
    if (sh > 15) return 16'sh0000;
    y = y - ((y * (u & 15)) >>> 5);
    return 16'(y >>> sh);
  endfunction : atten

  function automatic logic signed [15:0] sat(input int x);
    if (x > 32767) return 16'sh7fff;
    if (x < -32768) return 16'sh8000;
    return 16'(x);
  endfunction : sat

  // register file
  always_comb begin
    lfo_d  = lfo_q;
    lvl_d  = lvl_q;
    eff_d  = eff_q;
    fenv_d = fenv_q;
    flvl_d = flvl_q;
    rdata_d = 32'h0000_0000;
    if (WR) begin
      unique case (ADDR)
        slm_pkg::A_LFO:    lfo_d  = WDATA;
        slm_pkg::A_LEVEL:  lvl_d  = WDATA;
        slm_pkg::A_EFFECT: eff_d  = WDATA;
        slm_pkg::A_FENV:   fenv_d = WDATA;
        slm_pkg::A_FLVL:   flvl_d = WDATA;
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        slm_pkg::A_LFO:    rdata_d = lfo_q;
        slm_pkg::A_LEVEL:  rdata_d = lvl_q;
        slm_pkg::A_EFFECT: rdata_d = eff_q;
        slm_pkg::A_FENV:   rdata_d = fenv_q;
        slm_pkg::A_FLVL:   rdata_d = flvl_q;
        slm_pkg::A_STAT:   rdata_d = {2'b00, eff_rate, 11'h000, env_q};
        slm_pkg::A_LFOST:  rdata_d = {cents_q, 8'h00, pitch_mod_value,
                                      amp_mod_value};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // lfo shapes from the phase top byte, noise from the lfsr
  logic [7:0] ph, tri_u;
  assign ph    = phase_q[slm_pkg::PHASE_W-1 -: 8];
  assign tri_u = ph[7] ? ~{ph[6:0], 1'b0} : {ph[6:0], 1'b0};
  always_comb begin
    unique case (slm_pkg::slm_wave_t'(amp_mod_wave_sel))
      slm_pkg::WV_SAW:    amp_mod_value = ph;
      slm_pkg::WV_SQUARE: amp_mod_value = ph[7] ? 8'hff : 8'h00;
      slm_pkg::WV_TRI:    amp_mod_value = tri_u;
      slm_pkg::WV_NOISE:  amp_mod_value = lfsr_q[7:0];
    endcase
    unique case (slm_pkg::slm_wave_t'(pitch_mod_wave_sel))
      slm_pkg::WV_SAW:    pitch_mod_value = ph ^ 8'h80;
      slm_pkg::WV_SQUARE: pitch_mod_value = ph[7] ? 8'h80 : 8'h7f;
      slm_pkg::WV_TRI:    pitch_mod_value = tri_u ^ 8'h80;
      slm_pkg::WV_NOISE:  pitch_mod_value = lfsr_q[15:8];
    endcase
  end

  // filter envelope rate and step period
  int rate_sum, ch_att, mdir, eff_src, dl, dr, el, er, cut, damp, cents_i;
  logic signed [15:0] filt, src;
  logic signed [23:0] high;
  always_comb begin
    rate_sum = 2 * (int'(key_rate_scale) + int'($signed(octave_sel)))
               + int'(pitch_fraction_msb) + 2 * int'(fenv_rate);
    if (rate_sum < 0) rate_sum = 0;
    if (rate_sum > slm_pkg::RATE_MAX) rate_sum = slm_pkg::RATE_MAX;
    eff_rate = 6'(rate_sum);
    env_period = 32'((longint'(slm_pkg::FEG_MS[eff_rate])
                      * (slm_pkg::CLK_HZ / 1000))
                     / (slm_pkg::ENV_SPAN * FEG_TIME_DIV));
  end

  // sample path
  always_comb begin
    take = IN_VALID && IN_READY;
    // resonance fixed per channel, cutoff follows the envelope
    damp = 256 - int'(resonance);
    cut  = int'(env_q);
    high = 24'(int'($signed(IN_SAMPLE)) * 16 - int'(low_q)
               - ((damp * int'(band_q)) >>> 7));
    band_d = band_q;
    low_d  = low_q;
    if (take) begin
      // 13-bit cutoff times 24-bit state needs 64-bit headroom
      low_d  = 24'(longint'(low_q)
                   + ((longint'(cut) * longint'(band_q)) >>> 13));
      band_d = 24'(longint'(band_q)
                   + ((longint'(cut) * longint'(high)) >>> 13));
    end
    filt = sat(int'(low_d) >>> 4);
    // level, amplitude envelope and lfo swing sum first
    ch_att = int'(total_level_atten) + int'(ENV_ATTEN)
             + ((amp_mod_depth == 3'd0) ? 0
                : (int'(amp_mod_value) >> (9 - int'(amp_mod_depth))));
    mdir = vol_att(master_volume);
    if (eff_slot < 5'h10) src = DSP_OUT[16*eff_slot +: 16];
    else if (eff_slot == slm_pkg::SLOT_EXT_L) src = EXT_L;
    else if (eff_slot == slm_pkg::SLOT_EXT_R) src = EXT_R;
    else src = 16'sh0000;
    eff_src = vol_att(effect_send_level) + mdir;
    dl = int'(atten(filt, ch_att + vol_att(direct_send_level) + mdir
                         + pan_att(direct_pan, 1'b0)));
    dr = int'(atten(filt, ch_att + vol_att(direct_send_level) + mdir
                         + pan_att(direct_pan, 1'b1)));
    el = int'(atten(src, eff_src + pan_att(effect_pan, 1'b0)));
    er = int'(atten(src, eff_src + pan_att(effect_pan, 1'b1)));
    word = {sat(dl + el), sat(dr + er),
            atten(filt, ch_att + vol_att(input_mix_send_level))};
  end

  // lfo, noise, pitch offset and envelope
  always_comb begin
    phase_d  = phase_q;
    lfsr_d   = lfsr_q;
    cents_d  = cents_q;
    if (take) begin
      phase_d = phase_q + lfo_inc(lfo_rate_sel);
      lfsr_d  = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                 ^ lfsr_q[10]};
    end
    // about 3.5 cents times 2^(depth-1) at full swing
    cents_i = (pitch_mod_depth == 3'd0) ? 0
              : (int'($signed(pitch_mod_value)) * 7
                 * (1 << int'(pitch_mod_depth))) >>> 9;
    // depth 7 swings past the 8-bit port, so it clips rather than wraps
    if (cents_i > 127) cents_i = 127;
    if (cents_i < -128) cents_i = -128;
    cents_d = 8'(cents_i);
    env_d     = env_q;
    env_cnt_d = env_cnt_q;
    if (WR && ADDR == slm_pkg::A_FLVL) begin
      env_d     = WDATA[slm_pkg::LVL_W-1:0];
      env_cnt_d = 32'h0000_0000;
    end else if (eff_rate >= slm_pkg::RATE_HOLD
                 && env_q != flvl_q[16 +: slm_pkg::LVL_W]) begin
      env_cnt_d = env_cnt_q + 32'h0000_0001;
      if (env_cnt_q >= env_period) begin
        env_cnt_d = 32'h0000_0000;
        env_d = (env_q < flvl_q[16 +: slm_pkg::LVL_W]) ? env_q + 13'h0001
                                                      : env_q - 13'h0001;
      end
    end
  end

  // two-entry output buffer: head feeds the pins, skid absorbs a stall
  always_comb begin
    head_d = head_q;
    skid_d = skid_q;
    hv_d   = hv_q;
    sv_d   = sv_q;
    if (hv_q && OUT_READY) begin
      hv_d   = sv_q;
      head_d = skid_q;
      sv_d   = 1'b0;
    end
    if (take) begin
      if (!hv_d) begin
        hv_d   = 1'b1;
        head_d = word;
      end else begin
        sv_d   = 1'b1;
        skid_d = word;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lfo_q     <= 32'h0000_0000;
      lvl_q     <= 32'h0f0f_000f;
      eff_q     <= 32'h0000_0000;
      fenv_q    <= 32'h0000_0000;
      flvl_q    <= {3'b000, slm_pkg::ENV_HI, 3'b000, slm_pkg::ENV_HI};
      RDATA     <= 32'h0000_0000;
      phase_q   <= '0;
      lfsr_q    <= 16'h0001;
      cents_q   <= 8'h00;
      env_q     <= slm_pkg::ENV_HI;
      env_cnt_q <= 32'h0000_0000;
      low_q     <= 24'sh000000;
      band_q    <= 24'sh000000;
      head_q    <= '0;
      skid_q    <= '0;
      hv_q      <= 1'b0;
      sv_q      <= 1'b0;
      IN_READY  <= 1'b0;
    end else begin
      lfo_q     <= lfo_d;
      lvl_q     <= lvl_d;
      eff_q     <= eff_d;
      fenv_q    <= fenv_d;
      flvl_q    <= flvl_d;
      RDATA     <= rdata_d;
      phase_q   <= phase_d;
      lfsr_q    <= lfsr_d;
      cents_q   <= cents_d;
      env_q     <= env_d;
      env_cnt_q <= env_cnt_d;
      low_q     <= low_d;
      band_q    <= band_d;
      head_q    <= head_d;
      skid_q    <= skid_d;
      hv_q      <= hv_d;
      sv_q      <= sv_d;
      // ready only with the skid free after this edge; low for a cycle after each take, so at most one word every two cycles
      IN_READY  <= !sv_d && !(take && IN_READY);
    end
  end

  assign OUT_L       = head_q[47:32];
  assign OUT_R       = head_q[31:16];
  assign MIX_OUT     = head_q[15:0];
  assign OUT_VALID   = hv_q;
  assign PITCH_CENTS = cents_q;
endmodule : slm_mixer
`default_nettype wire

// ==== design/slm_pkg.sv ====
package slm_pkg;
  localparam int CLK_HZ     = 125_000_000;
  localparam int SAMPLE_HZ  = 44_100;
  localparam int PHASE_W    = 24;
  localparam int LVL_W      = 13;
  // register word indices
  localparam logic [3:0] A_LFO    = 4'h0;
  localparam logic [3:0] A_LEVEL  = 4'h1;
  localparam logic [3:0] A_EFFECT = 4'h2;
  localparam logic [3:0] A_FENV   = 4'h3;
  localparam logic [3:0] A_FLVL   = 4'h4;
  localparam logic [3:0] A_STAT   = 4'h5;
  localparam logic [3:0] A_LFOST  = 4'h6;
  // attenuation unit is 0.375 dB: 3 dB = 8 units, 6 dB = 16 units
  localparam int STEP3DB    = 8;
  localparam int MUTE_ATT   = 1023;
  localparam logic [4:0] SLOT_EXT_L = 5'h10;
  localparam logic [4:0] SLOT_EXT_R = 5'h11;
  localparam logic [3:0] VOL_FULL   = 4'hf;
  localparam logic [LVL_W-1:0] ENV_LO = 13'h0008;
  localparam logic [LVL_W-1:0] ENV_HI = 13'h1ff8;
  localparam int ENV_SPAN   = 'h1ff0;
  localparam int RATE_MAX   = 63;
  localparam int RATE_HOLD  = 2;
  // lfo rates in hundredths of a hertz
  localparam int LFO_CHZ [32] = '{
    17, 19, 23, 27, 34, 39, 45, 55, 68, 78, 92, 110, 139, 160, 187, 227,
    287, 331, 392, 479, 615, 718, 860, 1080, 1440, 1720, 2150, 2870,
    4310, 5740, 8610, 17230};
  // filter envelope sweep time in ms, 0 means never moves
  localparam int FEG_MS [64] = '{
    0, 0, 472800, 405200, 354400, 283600, 236400, 202800,
    177200, 142000, 118400, 101200, 88800, 70800, 59200, 50800,
    44400, 35600, 29600, 25200, 22000, 17600, 14800, 12800,
    11200, 8800, 7200, 6400, 5600, 4400, 3680, 3160,
    2760, 2200, 1840, 1560, 1360, 1080, 920, 800,
    680, 560, 440, 392, 340, 272, 228, 196,
    172, 34, 136, 100, 88, 72, 56, 48,
    44, 34, 28, 24, 22, 17, 14, 12};
  typedef enum logic [1:0] {WV_SAW, WV_SQUARE, WV_TRI, WV_NOISE} slm_wave_t;
endpackage : slm_pkg

// ==== testbench/slm_mixer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module slm_mixer_bench;
  logic         ref_clk, rst, rd, wr, in_valid, out_ready, in_ready;
  logic         out_valid, stream_on, stall;
  logic [3:0]   addr;
  logic [31:0]  wdata, rdata, d, f;
  logic [15:0]  in_sample, ext_l, ext_r, out_l, out_r, mix_out;
  logic [9:0]   env_atten;
  logic [255:0] dsp_out;
  logic [7:0]   pitch_cents;
  logic [2:0]   mute;
  logic [12:0]  s;
  logic [16:0]  exp_q [$];
  logic [16:0]  e;
  logic [1:0]   ext_sel;
  int           fail_count, n_tests, takes, outs, t0, m, prev;
  slm_mixer #(.FEG_TIME_DIV(100)) slm_mixer_i (
    .REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IN_SAMPLE(in_sample), .IN_VALID(in_valid),
    .IN_READY(in_ready), .ENV_ATTEN(env_atten), .DSP_OUT(dsp_out),
    .EXT_L(ext_l), .EXT_R(ext_r), .OUT_L(out_l), .OUT_R(out_r),
    .MIX_OUT(mix_out), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .PITCH_CENTS(pitch_cents));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  function automatic logic [5:0] exp_rate(input logic [31:0] x);
    int r;
    r = 2 * (int'(x[11:8]) + int'($signed(x[15:12]))) + int'(x[16])
      + 2 * int'(x[4:0]);
    return (r < 0) ? 6'h0 : (r > 63) ? 6'h3f : 6'(r);
  endfunction : exp_rate
  // source holds a word until taken; sink stalls at random
  always @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      takes++;
      exp_q.push_back({ext_sel != 2'h0, ext_sel[1] ? ext_r : ext_l});
    end
    if (out_valid && out_ready) begin
      outs++;
      e = exp_q.pop_front();
      if (e[16]) begin
        check("ext out_l", 32'(e[15:0]), 32'(out_l));
        check("ext out_r", 32'(e[15:0]), 32'(out_r));
        check("ext mix_out", 32'h0, 32'(mix_out));
      end
      if (mute[0]) check("out_l", 32'h0, 32'(out_l));
      if (mute[1]) check("out_r", 32'h0, 32'(out_r));
      if (mute[2]) check("mix_out", 32'h0, 32'(mix_out));
    end
    if (!in_valid || in_ready) begin
      in_valid  <= stream_on && 1'($urandom_range(0, 1));
      in_sample <= 16'($urandom);
    end
    out_ready <= !stall && ($urandom_range(0, 3) != 0);
    env_atten <= 10'($urandom);
    ext_l     <= 16'($urandom);
    ext_r     <= 16'($urandom);
    dsp_out   <= {8{$urandom}};
  end
  task automatic run(input int n);
    stream_on = 1'b1;
    repeat (n) @(posedge ref_clk);
    stream_on = 1'b0;
    repeat (40) @(posedge ref_clk);
  endtask : run
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
  initial begin
    {rd, wr, in_valid, out_ready, stream_on, stall, addr, ext_sel} = 12'h0;
    {wdata, in_sample, ext_l, ext_r, env_atten, dsp_out, mute} = 'h0;
    rst = 1'b1;
    void'($urandom(32'h3f188f30));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(slm_pkg::A_LEVEL, d);
    check("level reset", 32'h0f0f000f, d);
    rd_reg(slm_pkg::A_FLVL, d);
    check("flvl reset", 32'h1ff81ff8, d);
    for (int a = 7; a < 16; a++) begin
      rd_reg(4'(a), d);
      check("unmapped", 32'h0, d);
    end
    for (int i = 0; i < 24; i++) begin
      f = (i == 0) ? 32'h17f1f : (i == 1) ? 32'h8000 : $urandom;
      wr_reg(slm_pkg::A_FENV, f);
      wr_reg(slm_pkg::A_STAT, $urandom);
      rd_reg(slm_pkg::A_STAT, d);
      check("rate", 32'(exp_rate(f)), 32'(d[29:24]));
    end
    for (int i = 0; i < 2; i++) begin
      s = 13'($urandom);
      wr_reg(slm_pkg::A_FENV, i ? 32'h10000 : 32'h8000);
      wr_reg(slm_pkg::A_FLVL, {19'h1ff8, s});
      repeat (300) @(posedge ref_clk);
      rd_reg(slm_pkg::A_STAT, d);
      check("env hold", 32'(s), 32'(d[12:0]));
    end
    wr_reg(slm_pkg::A_FENV, 32'h17f1f);
    wr_reg(slm_pkg::A_FLVL, 32'h1ff80008);
    repeat (200) @(posedge ref_clk);
    rd_reg(slm_pkg::A_STAT, d);
    check("env moves", 32'h1, 32'(d[12:0] > 13'h8));
    // no takes yet, so the square pitch shape stands still while depth grows
    prev = 0;
    for (int k = 0; k < 8; k++) begin
      wr_reg(slm_pkg::A_LFO, 32'h1000 | (32'(k) << 16));
      rd_reg(slm_pkg::A_LFOST, d);
      m = int'($signed(d[31:24]));
      if (m < 0) m = -m;
      check("cents port", 32'(d[31:24]), 32'(pitch_cents));
      if (k == 0) check("cents off", 32'h0, 32'(d[31:24]));
      else check("cents grow", 32'h1, 32'(m > prev));
      prev = m;
    end
    wr_reg(slm_pkg::A_EFFECT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr_reg(slm_pkg::A_LEVEL, i == 0 ? 32'h000f0000 :
             i == 1 ? 32'h0f0f0f00 : 32'h0f1f0f00);
      mute = (i == 0) ? 3'h7 : (i == 1) ? 3'h5 : 3'h6;
      run(300);
      mute = 3'h0;
    end
    // direct path muted, effect path at 0 dB from the external inputs EXT_L and EXT_R
    wr_reg(slm_pkg::A_LEVEL, 32'h0f000000);
    for (int i = 0; i < 2; i++) begin
      wr_reg(slm_pkg::A_EFFECT, i ? 32'h0011100f : 32'h0010100f);
      ext_sel = i ? 2'h2 : 2'h1;
      run(200);
      ext_sel = 2'h0;
    end
    stall     = 1'b1;
    stream_on = 1'b1;
    repeat (3) @(posedge ref_clk);
    t0 = takes;
    repeat (30) @(posedge ref_clk);
    check("stall takes", 32'h1, 32'(takes - t0 <= 3));
    check("ready in stall", 32'h0, 32'(in_ready));
    stall = 1'b0;
    run(1500);
    check("words out", 32'(takes), 32'(outs));
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(slm_pkg::A_LEVEL, d);
    check("level after reset", 32'h0f0f000f, d);
    check("valid after reset", 32'h0, 32'(out_valid));
    wrap_up();
  end
endmodule : slm_mixer_bench
bind slm_mixer slm_mixer_props slm_mixer_props_i (
  .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
  .OUT_L(OUT_L), .OUT_R(OUT_R), .MIX_OUT(MIX_OUT), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY));
`default_nettype wire

// ==== testbench/slm_mixer_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module slm_mixer_props (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IN_VALID,
  input wire logic        IN_READY,
  input wire logic [15:0] OUT_L,
  input wire logic [15:0] OUT_R,
  input wire logic [15:0] MIX_OUT,
  input wire logic        OUT_VALID,
  input wire logic        OUT_READY
);
  logic [31:0] fenv_q, fenv_d;
  logic [12:0] start_q, start_d;
  logic        known_q, known_d;
  logic        held_q, held_d;
  int          eff_raw;
  logic [5:0]  eff_exp;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  always_comb begin
    eff_raw = 2 * (int'(fenv_q[11:8]) + int'($signed(fenv_q[15:12])))
            + int'(fenv_q[16]) + 2 * int'(fenv_q[4:0]);
    eff_exp = (eff_raw < 0) ? 6'h0 : (eff_raw > 63) ? 6'h3f : 6'(eff_raw);
    fenv_d  = fenv_q;
    known_d = known_q;
    start_d = start_q;
    held_d  = held_q;
    if (WR && ADDR == slm_pkg::A_FENV) begin
      fenv_d  = WDATA;
      known_d = 1'b1;
      held_d  = 1'b0;
    end
    if (WR && ADDR == slm_pkg::A_FLVL) begin
      start_d = WDATA[12:0];
      held_d  = known_q && eff_exp < 6'h2;
    end
  end
  // only trust a hold once rate and start were both written by software
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      fenv_q  <= 32'h0;
      start_q <= 13'h0;
      known_q <= 1'b0;
      held_q  <= 1'b0;
    end else begin
      fenv_q  <= fenv_d;
      start_q <= start_d;
      known_q <= known_d;
      held_q  <= held_d;
    end
  end
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside read answer");
  chk_unmapped_read: assert property (RD && ADDR > 4'h6 |=> RDATA == 32'h0)
    else $error("unmapped read returned data");
  chk_eff_rate: assert property (
    known_q && RD && ADDR == slm_pkg::A_STAT |=> RDATA[29:24] == eff_exp)
    else $error("effective rate wrong");
  chk_env_hold: assert property (
    held_q && RD && ADDR == slm_pkg::A_STAT |=> RDATA[12:0] == start_q)
    else $error("envelope moved at a holding rate");
  chk_ready_gap: assert property (IN_VALID && IN_READY |=> !IN_READY)
    else $error("ready high right after a take");
  chk_out_follows: assert property (
    IN_VALID && IN_READY && !OUT_VALID |=> OUT_VALID)
    else $error("no output one cycle after take");
  chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID
    && $stable(OUT_L) && $stable(OUT_R) && $stable(MIX_OUT))
    else $error("output changed while stalled");
  chk_valid_cause: assert property (
    $rose(OUT_VALID) |-> $past(IN_VALID && IN_READY))
    else $error("output valid without a take");
  chk_ready_back: assert property (
    IN_VALID && IN_READY && !OUT_VALID ##1 OUT_READY |=> IN_READY)
    else $error("ready did not return after drain");
endmodule : slm_mixer_props
`default_nettype wire
